// >>> common/serial_sar_adc_readout_regs.vh
// constants for the serial converter readout block
// assumes a 20 MHz system clock sampling the select and shift-clock pins
`ifndef SERIAL_SAR_ADC_READOUT_REGS_VH
`define SERIAL_SAR_ADC_READOUT_REGS_VH

// ************************************************************
// frame edge numbers
// ************************************************************
`define HOLD_END_RISE       5'h0d  // rising edge that ends hold
`define LAST_FALL           5'h10  // falling edge that ends the word
`define SHUTDOWN_MIN_FALL   5'h02  // earliest fall for shutdown abort
`define NORMAL_MIN_FALL     5'h0a  // fall that keeps normal mode
`define LEAD_ZEROS          5'h03  // leading zero bits before result
`define RESULT_BITS         12     // result width

// ************************************************************
// timing
// ************************************************************
`define CLOCK_HZ            20000000
`define ACQ_TIME_NS         350    // least track time before next fall
`define ACQ_CYCLES          8'h07  // least track time in system clocks

// ************************************************************
// reset values and buffer depth
// ************************************************************
`define RESULT_RESET        12'h000
`define FIFO_DEPTH          32

`endif

// >>> rtl/result_fifo.v
// synchronous fifo holding converted results
// assumes one clock and an active-low asynchronous reset
`default_nettype none

module result_fifo #(
  parameter WIDTH = 12,                // word width
  parameter DEPTH = 32,                // entries, power of two
  parameter AW    = 5                  // address width
) (
  input  wire             clock,       // system clock
  input  wire             rst_b,       // async reset, active low
  input  wire [WIDTH-1:0] inData,      // word to store
  input  wire             inValid,     // word offered
  output wire             inReady,     // room available
  output wire [WIDTH-1:0] outData,     // oldest word
  output wire             outValid,    // word available
  input  wire             outReady     // drain side takes word
);

  // ************************************************************
  // storage and pointers
  // ************************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1];     // entry array
  reg [AW:0]      wrPtr_r;             // write pointer with wrap bit
  reg [AW:0]      rdPtr_r;             // read pointer with wrap bit

  wire empty = (wrPtr_r == rdPtr_r);
  wire full  = (wrPtr_r[AW] != rdPtr_r[AW]) &&
               (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire push  = inValid && !full;
  wire pop   = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_r[AW-1:0]];

  // array write, no reset needed on data
  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // pointer update
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/serial_sar_adc_readout.v
// digital side of a 12-bit serial successive-approximation converter
// assumes the select and shift clock arrive asynchronously as pins;
// the analog core delivers one comparator decision per conversion step
`default_nettype none
`include "serial_sar_adc_readout_regs.vh"

module serial_sar_adc_readout #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,   // result buffer depth
  parameter FIFO_AW    = 5              // result buffer address width
) (
  input  wire        clock,             // 20 MHz system clock
  input  wire        rst_b,             // async reset, active low
  input  wire        selectPin_b,       // chip select pin, active low
  input  wire        shiftClkPin,       // serial clock pin
  input  wire        compareIn,         // comparator: input above dac
  output reg  [11:0] dacCode,           // trial code to the charge dac
  output reg         holdOn,            // 1 hold, 0 track
  output reg         serialResultOut,   // serial result data
  output reg         serialResultOe,    // serial result drive enable
  output reg         shutdownOn,        // analog core powered down
  output reg         resultValid,       // buffered result available
  output reg  [11:0] resultData,        // buffered result word
  input  wire        resultReady        // consumer takes result
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [1:0] selSync_r;                  // select two-stage sync
  reg [1:0] sclkSync_r;                 // shift clock two-stage sync
  reg       selD_r;                     // delayed synced select
  reg       sclkD_r;                    // delayed synced shift clock

  // sync stage one read only by stage two
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      selSync_r  <= 2'h3;
      sclkSync_r <= 2'h3;               // idle high: no false edge
      selD_r     <= 1'b1;
      sclkD_r    <= 1'b1;
    end else begin
      selSync_r  <= {selSync_r[0], selectPin_b};
      sclkSync_r <= {sclkSync_r[0], shiftClkPin};
      selD_r     <= selSync_r[1];
      sclkD_r    <= sclkSync_r[1];
    end
  end

  wire sel     = selSync_r[1];
  wire selFall = selD_r && !sel;
  wire selRise = !selD_r && sel;
  wire sckRise = !sclkD_r && sclkSync_r[1];
  wire sckFall = sclkD_r && !sclkSync_r[1];

  // ************************************************************
  // frame state
  // ************************************************************
  reg [4:0]  riseCnt_r;                 // rises since select fall
  reg [4:0]  fallCnt_r;                 // falls since select fall
  reg        frameOn_r;                 // select low, frame live
  reg        earlyZero_r;               // extra zero still owed
  reg [11:0] sar_r;                     // approximation register
  reg [3:0]  bitIdx_r;                  // bit under trial
  reg        powerUp_r;                 // first frame after shutdown
  reg        pushReq_r;                 // word ready for buffer

  wire fifoOutValid;                    // buffer has a word
  wire [11:0] fifoOutData;              // buffer head
  wire fifoPop = fifoOutValid && (!resultValid || resultReady);

  // main sequencing, paced only by select and shift-clock edges
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      riseCnt_r       <= 5'h00;
      fallCnt_r       <= 5'h00;
      frameOn_r       <= 1'b0;
      earlyZero_r     <= 1'b0;
      sar_r           <= `RESULT_RESET;
      bitIdx_r        <= 4'hb;
      powerUp_r       <= 1'b0;
      pushReq_r       <= 1'b0;
      dacCode         <= `RESULT_RESET;
      holdOn          <= 1'b0;
      serialResultOut <= 1'b0;
      serialResultOe  <= 1'b0;
      shutdownOn      <= 1'b0;
    end else begin
      // one-cycle offer: a full buffer drops the word, so that a
      // later frame can never overwrite a word still waiting
      if (pushReq_r) begin
        pushReq_r <= 1'b0;              // word offered once
      end
      if (selFall) begin
        riseCnt_r       <= 5'h00;
        fallCnt_r       <= 5'h00;
        frameOn_r       <= 1'b1;
        holdOn          <= 1'b1;
        serialResultOe  <= 1'b1;
        serialResultOut <= 1'b0;
        // clock already low: next fall may show an extra zero
        earlyZero_r     <= !sclkSync_r[1];
        sar_r           <= 12'h800;
        dacCode         <= 12'h800;
        bitIdx_r        <= 4'hb;
        powerUp_r       <= shutdownOn;
        shutdownOn      <= 1'b0;
      end else if (selRise) begin
        frameOn_r      <= 1'b0;
        serialResultOe <= 1'b0;
        holdOn         <= 1'b0;
        if (frameOn_r && fallCnt_r >= `SHUTDOWN_MIN_FALL &&
            fallCnt_r < `NORMAL_MIN_FALL) begin
          shutdownOn <= 1'b1;
        end else if (frameOn_r && powerUp_r &&
                     fallCnt_r < `NORMAL_MIN_FALL) begin
          shutdownOn <= 1'b1;
        end
        // after ten falls: truncated word, normal mode kept
      end else if (frameOn_r) begin
        if (sckRise) begin
          riseCnt_r <= riseCnt_r + 5'h01;
          if (riseCnt_r + 5'h01 == `HOLD_END_RISE) begin
            holdOn <= 1'b0;
          end
        end
        if (sckFall && fallCnt_r < `LAST_FALL) begin
          fallCnt_r <= fallCnt_r + 5'h01;
          if (earlyZero_r) begin
            earlyZero_r     <= 1'b0;
            serialResultOut <= 1'b0;
            fallCnt_r       <= fallCnt_r;
          end else if (fallCnt_r + 5'h01 == `LAST_FALL) begin
            serialResultOe  <= 1'b0;
            serialResultOut <= 1'b0;
            if (!powerUp_r) begin
              pushReq_r <= 1'b1;        // first after power-up dropped
            end
          end else if (fallCnt_r < `LEAD_ZEROS - 5'h01) begin
            serialResultOut <= 1'b0;
          end else begin
            // each step resolves one bit and shifts it out, MSB first
            serialResultOut <= compareIn;
            if (bitIdx_r != 4'h0) begin
              sar_r[bitIdx_r]       <= compareIn;
              sar_r[bitIdx_r-4'h1]  <= 1'b1;
              dacCode[bitIdx_r]     <= compareIn;
              dacCode[bitIdx_r-4'h1] <= 1'b1;
              bitIdx_r <= bitIdx_r - 4'h1;
            end else begin
              sar_r[0]   <= compareIn;
              dacCode[0] <= compareIn;
            end
          end
        end
      end else if (sel) begin
        serialResultOe <= 1'b0;
      end
    end
  end

  // ************************************************************
  // result buffer and consumer port
  // ************************************************************
  result_fifo #(
    .WIDTH (`RESULT_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) resultBuf (
    .clock    (clock),
    .rst_b    (rst_b),
    .inData   (sar_r),
    .inValid  (pushReq_r),
    .inReady  (),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // output stage register, keeps outputs straight from flip-flops
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resultValid <= 1'b0;
      resultData  <= `RESULT_RESET;
    end else if (fifoPop) begin
      resultValid <= 1'b1;
      resultData  <= fifoOutData;
    end else if (resultReady) begin
      resultValid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> tb/serial_sar_adc_readout_chk.sv
// pin-level assertions for the converter readout
// assumes pins change at most once per system clock
`default_nettype none
module serial_sar_adc_readout_chk (
  input wire logic clock,           // system clock
  input wire logic rst_b,           // reset, active low
  input wire logic selectPin_b,     // select, active low
  input wire logic shiftClkPin,     // shift clock pin
  input wire logic holdOn,          // hold phase
  input wire logic serialResultOut, // serial data
  input wire logic serialResultOe,  // data drive
  input wire logic shutdownOn       // powered down
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclkQ_r; // shift clock a cycle ago
  logic [4:0] falls_r; // falls since select fell
  logic [4:0] rises_r; // rises since select fell
  // raw pins, so this count leads the design by two cycles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclkQ_r <= 1'b1;
      falls_r <= 5'h00;
      rises_r <= 5'h00;
    end else begin
      sclkQ_r <= shiftClkPin;
      if (selectPin_b) begin // idle: next frame starts at zero
        falls_r <= 5'h00;
        rises_r <= 5'h00;
      end else begin
        falls_r <= falls_r + {4'h0, sclkQ_r & ~shiftClkPin};
        rises_r <= rises_r + {4'h0, ~sclkQ_r & shiftClkPin};
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_selFall; $fell(selectPin_b); endsequence
  sequence s_selRise; $rose(selectPin_b); endsequence
  property p_idleOff; selectPin_b [*6] |-> !serialResultOe; endproperty
  a_idleOff: assert property (p_idleOff) else $error("idle drive");
  property p_driveOn;
    s_selFall ##1 (!selectPin_b) [*5] |-> serialResultOe && holdOn;
  endproperty
  a_driveOn: assert property (p_driveOn) else $error("no start");
  property p_holdEnd;
    $fell(holdOn) && !selectPin_b |-> rises_r == 5'h0d;
  endproperty
  a_holdEnd: assert property (p_holdEnd) else $error("hold end");
  property p_oeEnd;
    $fell(serialResultOe) && !selectPin_b |-> falls_r == 5'h10;
  endproperty
  a_oeEnd: assert property (p_oeEnd) else $error("drive end");
  property p_leadZero;
    serialResultOe && !selectPin_b && falls_r < 5'h03 |-> !serialResultOut;
  endproperty
  a_leadZero: assert property (p_leadZero) else $error("lead bit");
  property p_shutIn;
    s_selRise ##0 (falls_r inside {[5'h02:5'h09]}) |-> ##[1:8] shutdownOn;
  endproperty
  a_shutIn: assert property (p_shutIn) else $error("no sleep");
  property p_stayOn;
    s_selRise ##0 (falls_r inside {[5'h0a:5'h10]}) |-> (!shutdownOn) [*8];
  endproperty
  a_stayOn: assert property (p_stayOn) else $error("slept");
  property p_wake;
    s_selFall ##0 shutdownOn |-> ##[1:8] !shutdownOn;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind serial_sar_adc_readout serial_sar_adc_readout_chk u_chk (
  .clock(clock), .rst_b(rst_b), .selectPin_b(selectPin_b),
  .shiftClkPin(shiftClkPin), .holdOn(holdOn),
  .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
  .shutdownOn(shutdownOn));
`default_nettype wire

// >>> tb/adc_host_model.sv
// host model: select, shift clock and comparator
// assumes the shift clock idles high between frames
`default_nettype none
module adc_host_model (
  input  wire logic clock,           // system clock
  input  wire logic serialResultOut, // serial data
  input  wire logic serialResultOe,  // data drive
  output logic      selectPin_b,     // select, active low
  output logic      shiftClkPin,     // shift clock
  output logic      compareIn        // comparator decision
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 200; // 400 ns shift clock
  initial begin
    selectPin_b = 1'b1;
    shiftClkPin = 1'b1;
    compareIn = 1'b0;
  end
  // samples late in each high phase; an undriven line reads as 1
  task automatic frame(input logic [11:0] code, input int falls,
                       output logic [16:0] word);
    word = 17'h00000;
    selectPin_b = 1'b0;
    #(2*HALF);
    for (int n = 1; n <= falls; n++) begin
      word = {word[15:0], serialResultOe ? serialResultOut : 1'b1};
      @(negedge clock);
      if (n >= 3 && n <= 14) compareIn = code[14-n];
      #7 shiftClkPin = 1'b0;
      #HALF shiftClkPin = 1'b1;
      if (n == 13) #(2*HALF);
      #(HALF-30);
    end
    word = {word[15:0], serialResultOe};
    selectPin_b = 1'b1;
    #(4*HALF);
  endtask
endmodule
`default_nettype wire

// >>> tb/serial_sar_adc_readout_tb_top.sv
// bench for the converter readout
// assumes the host model and the bound checker
`default_nettype none
module serial_sar_adc_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %0t %h %h", $time, g, e); end end
  logic        clock, rst_b, resultReady, stallOn; // bench driven
  wire         selectPin_b, shiftClkPin, compareIn, holdOn, shutdownOn;
  wire         serialResultOut, serialResultOe, resultValid;
  wire  [11:0] resultData, dacCode;                // buffered word, trial
  logic [11:0] expQ[$], expWord;                   // expected words
  int          seed = 32'he8f6, error_cnt = 0, total_checks = 0;
  // second 1: abort straight after waking falls back asleep
  int          abortFalls[5] = '{12, 1, 5, 1, 16}; // abort points
  logic        expShut[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  serial_sar_adc_readout dut (.clock(clock), .rst_b(rst_b),
    .selectPin_b(selectPin_b), .shiftClkPin(shiftClkPin), .dacCode(dacCode),
    .compareIn(compareIn), .holdOn(holdOn), .shutdownOn(shutdownOn),
    .serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
    .resultValid(resultValid), .resultData(resultData),
    .resultReady(resultReady));
  adc_host_model host (.clock(clock), .serialResultOut(serialResultOut),
    .serialResultOe(serialResultOe), .selectPin_b(selectPin_b),
    .shiftClkPin(shiftClkPin), .compareIn(compareIn));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // random drain stalls keep the buffer partly full
  always @(negedge clock) resultReady <= !stallOn && ($random(seed) & 1);
  // oldest note against each word leaving the buffer
  always @(posedge clock) begin
    if (resultValid === 1'b1 && resultReady === 1'b1) begin
      expWord = expQ.size() > 0 ? expQ.pop_front() : 12'hxxx;
      `CHECK(resultData, expWord)
    end
  end
  // note first: the word may leave before the frame task returns
  task automatic run(input int falls, input bit keep);
    logic [11:0] code;
    logic [16:0] word;
    code = $random(seed);
    // capacity is the buffer depth plus the output stage
    if (keep && expQ.size() < 33) expQ.push_back(code);
    host.frame(code, falls, word);
    if (keep) begin
      `CHECK(word[16:14], 3'h0)
      `CHECK(word[13:2], code)
      `CHECK(word[0], 1'b0)
      `CHECK(dacCode, code)
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    stallOn = 1'b0;
    repeat (12) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    repeat (5) @(negedge clock);
    repeat (4) run(16, 1);
    repeat (100) @(negedge clock);
    $display("test plain frames done");
    stallOn = 1'b1; // full buffer must refuse the extra word
    repeat (34) run(16, 1);
    `CHECK(resultValid, 1'b1)
    stallOn = 1'b0;
    repeat (200) @(negedge clock);
    `CHECK(expQ.size() == 0, 1'b1)
    $display("test buffer fill done");
    foreach (abortFalls[i]) begin
      run(abortFalls[i], 0);
      `CHECK(shutdownOn, expShut[i])
    end
    repeat (2) run(16, 1);
    repeat (100) @(negedge clock);
    `CHECK(expQ.size() == 0, 1'b1)
    $display("test abort and shutdown done");
    summarize();
  end
  initial begin
    #1000000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
